// file: vpsp_top.v
// Voice and stereo serial audio ports with register port and sample FIFOs

`include "vpsp_consts.vh"

module vpsp_fifo
#(
  parameter W  = 32,
  parameter D  = 16,
  parameter AW = 4
)
(
  // Clock, reset, enable
  input  wire          i_ref_clk,
  input  wire          i_srst,
  input  wire          i_ce,
  // Fill side
  input  wire          i_in_valid,
  input  wire [W-1:0]  i_in_data,
  output wire          o_in_ready,
  // Drain side
  output wire          o_out_valid,
  output wire [W-1:0]  o_out_data,
  input  wire          i_out_ready
);
  reg  [W-1:0] mem [0:D-1];
  reg  [AW-1:0] wptr;
  reg  [AW-1:0] rptr;
  reg  [AW:0]   count;
  wire          push;
  wire          pop;

  assign o_in_ready  = (count != D[AW:0]);
  assign o_out_valid = (count != {(AW+1){1'b0}});
  assign o_out_data  = mem[rptr];
  assign push        = i_in_valid & o_in_ready;
  assign pop         = i_out_ready & o_out_valid;

  always @(posedge i_ref_clk)
  begin
    if (i_srst)
    begin
      wptr  <= {AW{1'b0}};
      rptr  <= {AW{1'b0}};
      count <= {(AW+1){1'b0}};
    end
    else if (i_ce)
    begin
      if (push)
      begin
        mem[wptr] <= i_in_data;
        wptr      <= (wptr == D[AW-1:0] - 1'b1) ? {AW{1'b0}} : wptr + 1'b1;
      end
      if (pop)
        rptr <= (rptr == D[AW-1:0] - 1'b1) ? {AW{1'b0}} : rptr + 1'b1;
      if (push & ~pop)
        count <= count + 1'b1;
      else if (pop & ~push)
        count <= count - 1'b1;
    end
  end
endmodule

module vpsp_port
#(
  parameter RW = 20
)
(
  // Clock, reset, enable
  input  wire          i_ref_clk,
  input  wire          i_srst,
  input  wire          i_ce,
  // Configuration
  input  wire [`VPSP_CTRL_W-1:0] i_ctrl,
  input  wire [7:0]    i_div,
  // Bus pins
  input  wire          i_bclk,
  input  wire          i_fs,
  input  wire          i_rxd,
  output reg           o_bclk,
  output reg           o_bclk_oe,
  output reg           o_fs,
  output reg           o_fs_oe,
  output reg           o_txd,
  output reg           o_txd_oe,
  // Sample streams
  input  wire          i_tx_valid,
  input  wire [31:0]   i_tx_data,
  output wire          o_tx_pop,
  output reg           o_rx_valid,
  output reg  [31:0]   o_rx_data,
  input  wire          i_rx_ready,
  // Events and rate
  output reg           o_underrun,
  output reg           o_overrun,
  output reg  [RW-1:0] o_rate
);
  wire       en     = i_ctrl[`VPSP_B_EN];
  wire       master = i_ctrl[`VPSP_B_MAST];
  wire       clk_en = i_ctrl[`VPSP_B_CLKEN];
  wire       e_inv  = i_ctrl[`VPSP_B_EDGE];
  wire       long_s = i_ctrl[`VPSP_B_LONG];
  wire       fs_inv = i_ctrl[`VPSP_B_FSINV];
  wire       w32    = i_ctrl[`VPSP_B_W32];
  wire [1:0] slots  = i_ctrl[`VPSP_B_SLOTS+1:`VPSP_B_SLOTS];
  wire [1:0] tx_sl  = i_ctrl[`VPSP_B_TXSLOT+1:`VPSP_B_TXSLOT];
  wire [1:0] rx_sl  = i_ctrl[`VPSP_B_RXSLOT+1:`VPSP_B_RXSLOT];
  wire       tsb    = i_ctrl[`VPSP_B_TSB];

  // Frame length in bits
  function [7:0] frame_len;
    input       f_w32;
    input [1:0] f_slots;
    begin
      frame_len = (f_w32 ? 8'd32 : 8'd16) << ((f_slots == 2'd0) ? 2'd0 : (f_slots == 2'd1) ? 2'd1 : 2'd2);
    end
  endfunction

  // Slot index of a bit position
  function [1:0] pos_slot;
    input [7:0] p;
    input       f_w32;
    begin
      pos_slot = f_w32 ? p[6:5] : p[5:4];
    end
  endfunction

  // Bit index within a word
  function [4:0] pos_bit;
    input [7:0] p;
    input       f_w32;
    begin
      pos_bit = f_w32 ? p[4:0] : {1'b0, p[3:0]};
    end
  endfunction

  reg  [1:0]    bclk_sy;
  reg  [1:0]    fs_sy;
  reg  [1:0]    rxd_sy;
  reg           bclk_d;
  reg           fs_d;
  reg  [7:0]    div_cnt;
  reg           bclk_gen;
  reg  [7:0]    pos;
  reg  [7:0]    next_pos;
  reg           short_pend;
  reg  [31:0]   tx_sh;
  reg  [31:0]   rx_sh;
  reg  [RW-1:0] rate_cnt;

  wire [7:0] total    = frame_len(w32, slots);
  wire [4:0] last_bit = w32 ? 5'd31 : 5'd15;
  wire       gen_on   = en & master & clk_en;
  wire       tick     = gen_on & (div_cnt == i_div);
  wire       m_rise   = tick & ~bclk_gen;
  wire       m_fall   = tick & bclk_gen;
  wire       s_rise   = en & ~master & bclk_sy[1] & ~bclk_d;
  wire       s_fall   = en & ~master & ~bclk_sy[1] & bclk_d;
  wire       rise     = master ? m_rise : s_rise;
  wire       fall     = master ? m_fall : s_fall;
  wire       launch   = e_inv ? fall : rise;
  wire       sample   = e_inv ? rise : fall;
  wire       fs_act   = fs_sy[1] ^ fs_inv;
  wire       l_start  = en & ~master & long_s & fs_act & ~fs_d;
  wire       step     = launch | l_start;
  wire       in_tx    = (next_pos < total) & (pos_slot(next_pos, w32) == tx_sl);
  wire       cur_tx   = (pos < total) & (pos_slot(pos, w32) == tx_sl);
  wire       tx_first = in_tx & (pos_bit(next_pos, w32) == 5'd0);
  wire       in_rx    = (pos < total) & (pos_slot(pos, w32) == rx_sl);
  wire [31:0] tx_load = w32 ? i_tx_data : {i_tx_data[15:0], 16'h0000};
  wire [31:0] rx_word = w32 ? {rx_sh[30:0], rxd_sy[1]} : {{16{rx_sh[14]}}, rx_sh[14:0], rxd_sy[1]};

  assign o_tx_pop = i_ce & step & tx_first & i_tx_valid;

  // Next bit position of the frame
  always @*
  begin
    next_pos = pos;
    if (l_start)
      next_pos = 8'h00;
    else if (launch)
    begin
      if (master)
        next_pos = (pos >= total - 8'd1) ? 8'h00 : pos + 8'd1;
      else if (short_pend)
        next_pos = 8'h00;
      else if (pos < total)
        next_pos = pos + 8'd1;
    end
  end

  always @(posedge i_ref_clk)
  begin
    if (i_srst)
    begin
      bclk_sy    <= 2'h0;
      fs_sy      <= 2'h0;
      rxd_sy     <= 2'h0;
      bclk_d     <= 1'b0;
      fs_d       <= 1'b0;
      div_cnt    <= 8'h00;
      bclk_gen   <= 1'b0;
      pos        <= 8'hff;
      short_pend <= 1'b0;
      tx_sh      <= 32'h00000000;
      rx_sh      <= 32'h00000000;
      rate_cnt   <= {RW{1'b0}};
      o_rate     <= {RW{1'b0}};
      o_bclk     <= 1'b0;
      o_bclk_oe  <= 1'b0;
      o_fs       <= 1'b0;
      o_fs_oe    <= 1'b0;
      o_txd      <= 1'b0;
      o_txd_oe   <= 1'b0;
      o_rx_valid <= 1'b0;
      o_rx_data  <= 32'h00000000;
      o_underrun <= 1'b0;
      o_overrun  <= 1'b0;
    end
    else if (i_ce)
    begin
      // Pin synchronisers
      bclk_sy <= {bclk_sy[0], i_bclk};
      fs_sy   <= {fs_sy[0], i_fs};
      rxd_sy  <= {rxd_sy[0], i_rxd};
      bclk_d  <= bclk_sy[1];
      fs_d    <= fs_act;
      // Bit clock divider
      if (!gen_on)
      begin
        div_cnt  <= 8'h00;
        bclk_gen <= 1'b0;
      end
      else if (tick)
      begin
        div_cnt  <= 8'h00;
        bclk_gen <= ~bclk_gen;
      end
      else
        div_cnt <= div_cnt + 8'd1;
      o_bclk    <= bclk_gen;
      o_bclk_oe <= gen_on;
      o_fs_oe   <= gen_on;
      if (!gen_on)
        o_fs <= fs_inv;
      else if (launch)
        o_fs <= (long_s ? (next_pos < {3'b000, last_bit} + 8'd1) : (next_pos == total - 8'd1)) ^ fs_inv;
      // Short sync seen as slave
      if (!en || master || long_s)
        short_pend <= 1'b0;
      else if (sample && fs_act)
        short_pend <= 1'b1;
      else if (launch)
        short_pend <= 1'b0;
      if (!en)
        pos <= 8'hff;
      else if (step)
        pos <= next_pos;
      // Transmit shifter
      o_underrun <= 1'b0;
      if (!en)
      begin
        o_txd    <= 1'b0;
        o_txd_oe <= 1'b0;
      end
      else if (step)
      begin
        if (tx_first)
        begin
          o_txd      <= i_tx_valid & tx_load[31];
          tx_sh      <= i_tx_valid ? {tx_load[30:0], 1'b0} : 32'h00000000;
          o_underrun <= ~i_tx_valid;
          o_txd_oe   <= 1'b1;
        end
        else if (in_tx)
        begin
          o_txd    <= tx_sh[31];
          tx_sh    <= {tx_sh[30:0], 1'b0};
          o_txd_oe <= 1'b1;
        end
        else
        begin
          o_txd    <= 1'b0;
          o_txd_oe <= ~tsb;
        end
      end
      else if (!cur_tx)
      begin
        o_txd    <= 1'b0;
        o_txd_oe <= ~tsb;
      end
      // Receive shifter
      o_rx_valid <= 1'b0;
      o_overrun  <= 1'b0;
      if (en && sample && in_rx)
      begin
        rx_sh <= {rx_sh[30:0], rxd_sy[1]};
        if (pos_bit(pos, w32) == last_bit)
        begin
          o_rx_valid <= i_rx_ready;
          o_rx_data  <= rx_word;
          o_overrun  <= ~i_rx_ready;
        end
      end
      // Frame rate measurement as slave
      if (step && next_pos == 8'h00 && !master)
      begin
        o_rate   <= rate_cnt;
        rate_cnt <= {RW{1'b0}};
      end
      else if (rate_cnt != {RW{1'b1}})
        rate_cnt <= rate_cnt + 1'b1;
    end
  end
endmodule

module vpsp_top
#(
  parameter FIFO_D  = 16,
  parameter FIFO_AW = 4,
  parameter RW      = 20
)
(
  // Clock, reset, enable
  input  wire          i_ref_clk,
  input  wire          i_srst,
  input  wire          i_ce,
  // Register port
  input  wire [3:0]    i_addr,
  input  wire [31:0]   i_wdata,
  input  wire          i_wr,
  input  wire          i_rd,
  output reg  [31:0]   o_rdata,
  // Output drive strength
  output reg  [1:0]    o_drive_strength,
  // Voice bus pins
  input  wire          i_v_bclk,
  input  wire          i_v_fs,
  input  wire          i_v_rxd,
  output wire          o_v_bclk,
  output wire          o_v_bclk_oe,
  output wire          o_v_fs,
  output wire          o_v_fs_oe,
  output wire          o_v_txd,
  output wire          o_v_txd_oe,
  // Stereo bus pins
  input  wire          i_s_bclk,
  input  wire          i_s_fs,
  input  wire          i_s_rxd,
  output wire          o_s_bclk,
  output wire          o_s_bclk_oe,
  output wire          o_s_fs,
  output wire          o_s_fs_oe,
  output wire          o_s_txd,
  output wire          o_s_txd_oe
);
  reg  [`VPSP_CTRL_W-1:0] vctrl;
  reg  [`VPSP_CTRL_W-1:0] sctrl;
  reg  [7:0]   vdiv;
  reg  [7:0]   sdiv;
  reg  [3:0]   sticky;
  wire [31:0]  vtx_d;
  wire [31:0]  stx_d;
  wire [31:0]  vrx_w;
  wire [31:0]  srx_w;
  wire [31:0]  vrx_d;
  wire [31:0]  srx_d;
  wire [RW-1:0] vrate;
  wire [RW-1:0] srate;
  wire         vtx_rdy;
  wire         stx_rdy;
  wire         vtx_val;
  wire         stx_val;
  wire         vtx_pop;
  wire         stx_pop;
  wire         vrx_push;
  wire         srx_push;
  wire         vrx_rdy;
  wire         srx_rdy;
  wire         vrx_val;
  wire         srx_val;
  wire         v_und;
  wire         s_und;
  wire         v_ovr;
  wire         s_ovr;
  wire         vrx_pop = i_rd & (i_addr == `VPSP_A_VRX);
  wire         srx_pop = i_rd & (i_addr == `VPSP_A_SRX);
  wire         wr_stat = i_wr & (i_addr == `VPSP_A_STAT);
  wire [3:0]   ev      = {s_und, v_und, s_ovr, v_ovr};

  // Register writes and read data
  always @(posedge i_ref_clk)
  begin
    if (i_srst)
    begin
      vctrl            <= `VPSP_CTRL_RST;
      sctrl            <= `VPSP_CTRL_RST;
      vdiv             <= `VPSP_DIV_RST;
      sdiv             <= `VPSP_DIV_RST;
      o_drive_strength <= `VPSP_DRIVE_RST;
      sticky           <= 4'h0;
      o_rdata          <= 32'h00000000;
    end
    else if (i_ce)
    begin
      if (i_wr && i_addr == `VPSP_A_VCTRL)
        vctrl <= i_wdata[`VPSP_CTRL_W-1:0];
      if (i_wr && i_addr == `VPSP_A_SCTRL)
        sctrl <= i_wdata[`VPSP_CTRL_W-1:0];
      if (i_wr && i_addr == `VPSP_A_GCTRL)
        o_drive_strength <= i_wdata[`VPSP_B_DRIVE+1:`VPSP_B_DRIVE];
      if (i_wr && i_addr == `VPSP_A_VDIV)
        vdiv <= i_wdata[7:0];
      if (i_wr && i_addr == `VPSP_A_SDIV)
        sdiv <= i_wdata[7:0];
      sticky <= (sticky & ~(wr_stat ? i_wdata[`VPSP_B_SUND:`VPSP_B_VOVR] : 4'h0)) | ev;
      o_rdata <= 32'h00000000;
      if (i_rd)
      begin
        case (i_addr)
          `VPSP_A_VCTRL: o_rdata <= {{(32-`VPSP_CTRL_W){1'b0}}, vctrl};
          `VPSP_A_SCTRL: o_rdata <= {{(32-`VPSP_CTRL_W){1'b0}}, sctrl};
          `VPSP_A_GCTRL: o_rdata <= {30'h0, o_drive_strength};
          `VPSP_A_VDIV:  o_rdata <= {24'h000000, vdiv};
          `VPSP_A_SDIV:  o_rdata <= {24'h000000, sdiv};
          `VPSP_A_VRX:   o_rdata <= vrx_val ? vrx_d : 32'h00000000;
          `VPSP_A_SRX:   o_rdata <= srx_val ? srx_d : 32'h00000000;
          `VPSP_A_STAT:  o_rdata <= {24'h000000, sticky, srx_val, ~stx_rdy, vrx_val, ~vtx_rdy};
          `VPSP_A_VRATE: o_rdata <= {{(32-RW){1'b0}}, vrate};
          `VPSP_A_SRATE: o_rdata <= {{(32-RW){1'b0}}, srate};
          default:       o_rdata <= 32'h00000000;
        endcase
      end
    end
  end

  // Sample FIFOs
  vpsp_fifo #(.W(32), .D(FIFO_D), .AW(FIFO_AW)) u_vtx
  (
    .i_ref_clk(i_ref_clk), .i_srst(i_srst), .i_ce(i_ce),
    .i_in_valid(i_wr & (i_addr == `VPSP_A_VTX)), .i_in_data(i_wdata), .o_in_ready(vtx_rdy),
    .o_out_valid(vtx_val), .o_out_data(vtx_d), .i_out_ready(vtx_pop)
  );
  vpsp_fifo #(.W(32), .D(FIFO_D), .AW(FIFO_AW)) u_stx
  (
    .i_ref_clk(i_ref_clk), .i_srst(i_srst), .i_ce(i_ce),
    .i_in_valid(i_wr & (i_addr == `VPSP_A_STX)), .i_in_data(i_wdata), .o_in_ready(stx_rdy),
    .o_out_valid(stx_val), .o_out_data(stx_d), .i_out_ready(stx_pop)
  );
  vpsp_fifo #(.W(32), .D(FIFO_D), .AW(FIFO_AW)) u_vrx
  (
    .i_ref_clk(i_ref_clk), .i_srst(i_srst), .i_ce(i_ce),
    .i_in_valid(vrx_push), .i_in_data(vrx_w), .o_in_ready(vrx_rdy),
    .o_out_valid(vrx_val), .o_out_data(vrx_d), .i_out_ready(vrx_pop)
  );
  vpsp_fifo #(.W(32), .D(FIFO_D), .AW(FIFO_AW)) u_srx
  (
    .i_ref_clk(i_ref_clk), .i_srst(i_srst), .i_ce(i_ce),
    .i_in_valid(srx_push), .i_in_data(srx_w), .o_in_ready(srx_rdy),
    .o_out_valid(srx_val), .o_out_data(srx_d), .i_out_ready(srx_pop)
  );

  // Voice and stereo engines
  vpsp_port #(.RW(RW)) u_voice
  (
    .i_ref_clk(i_ref_clk), .i_srst(i_srst), .i_ce(i_ce), .i_ctrl(vctrl), .i_div(vdiv),
    .i_bclk(i_v_bclk), .i_fs(i_v_fs), .i_rxd(i_v_rxd),
    .o_bclk(o_v_bclk), .o_bclk_oe(o_v_bclk_oe), .o_fs(o_v_fs), .o_fs_oe(o_v_fs_oe),
    .o_txd(o_v_txd), .o_txd_oe(o_v_txd_oe),
    .i_tx_valid(vtx_val), .i_tx_data(vtx_d), .o_tx_pop(vtx_pop),
    .o_rx_valid(vrx_push), .o_rx_data(vrx_w), .i_rx_ready(vrx_rdy),
    .o_underrun(v_und), .o_overrun(v_ovr), .o_rate(vrate)
  );
  vpsp_port #(.RW(RW)) u_stereo
  (
    .i_ref_clk(i_ref_clk), .i_srst(i_srst), .i_ce(i_ce), .i_ctrl(sctrl), .i_div(sdiv),
    .i_bclk(i_s_bclk), .i_fs(i_s_fs), .i_rxd(i_s_rxd),
    .o_bclk(o_s_bclk), .o_bclk_oe(o_s_bclk_oe), .o_fs(o_s_fs), .o_fs_oe(o_s_fs_oe),
    .o_txd(o_s_txd), .o_txd_oe(o_s_txd_oe),
    .i_tx_valid(stx_val), .i_tx_data(stx_d), .o_tx_pop(stx_pop),
    .o_rx_valid(srx_push), .o_rx_data(srx_w), .i_rx_ready(srx_rdy),
    .o_underrun(s_und), .o_overrun(s_ovr), .o_rate(srate)
  );
endmodule

// file: vpsp_consts.vh
// Constants of the voice and stereo serial audio ports
`ifndef VPSP_CONSTS_VH
`define VPSP_CONSTS_VH
// Register offsets
`define VPSP_A_VCTRL   4'h0
`define VPSP_A_SCTRL   4'h1
`define VPSP_A_GCTRL   4'h2
`define VPSP_A_VDIV    4'h3
`define VPSP_A_SDIV    4'h4
`define VPSP_A_VTX     4'h5
`define VPSP_A_VRX     4'h6
`define VPSP_A_STX     4'h7
`define VPSP_A_SRX     4'h8
`define VPSP_A_STAT    4'h9
`define VPSP_A_VRATE   4'ha
`define VPSP_A_SRATE   4'hb
// Port control field positions
`define VPSP_B_EN      0
`define VPSP_B_MAST    1
`define VPSP_B_CLKEN   2
`define VPSP_B_EDGE    3
`define VPSP_B_LONG    4
`define VPSP_B_FSINV   5
`define VPSP_B_W32     6
`define VPSP_B_SLOTS   7
`define VPSP_B_TXSLOT  9
`define VPSP_B_RXSLOT  11
`define VPSP_B_TSB     13
`define VPSP_CTRL_W    14
// Global control field position
`define VPSP_B_DRIVE   0
// Status field positions
`define VPSP_B_VTXFULL 0
`define VPSP_B_VRXVAL  1
`define VPSP_B_STXFULL 2
`define VPSP_B_SRXVAL  3
`define VPSP_B_VOVR    4
`define VPSP_B_SOVR    5
`define VPSP_B_VUND    6
`define VPSP_B_SUND    7
// Reset values
`define VPSP_CTRL_RST  14'h2000
`define VPSP_DRIVE_RST 2'h0
`define VPSP_DIV_RST   8'h04
`endif

// file: vpsp_top_props.sv
// Port-level checks of the voice and stereo serial audio ports
`include "vpsp_consts.vh"
module vpsp_top_props (
  // Clock and reset
  input wire        i_ref_clk,
  input wire        i_srst,
  // Register port
  input wire [3:0]  i_addr,
  input wire [31:0] i_wdata,
  input wire        i_wr,
  input wire [1:0]  o_drive_strength,
  // Voice outputs
  input wire        o_v_bclk_oe,
  input wire        o_v_txd,
  input wire        o_v_txd_oe,
  // Stereo outputs
  input wire        o_s_bclk,
  input wire        o_s_bclk_oe,
  input wire        o_s_fs,
  input wire        o_s_fs_oe,
  input wire        o_s_txd
);
  timeunit 1ns;
  timeprecision 1ps;
  reg  [13:0] vctrl;
  reg  [13:0] sctrl;
  reg  [7:0]  sdiv;
  wire        vmode  = &vctrl[2:0];
  wire        smode  = &sctrl[2:0];
  wire        sclk4  = smode && sdiv == 8'h04;
  wire        sshort = sclk4 && !sctrl[`VPSP_B_LONG] && !sctrl[`VPSP_B_FSINV];
  wire        gwr    = i_wr && i_addr == `VPSP_A_GCTRL;

  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_srst);

  // Shadow copies of the port settings
  always @(posedge i_ref_clk)
  begin
    if (i_srst)
    begin
      vctrl <= `VPSP_CTRL_RST;
      sctrl <= `VPSP_CTRL_RST;
      sdiv  <= `VPSP_DIV_RST;
    end
    else if (i_wr)
    begin
      if (i_addr == `VPSP_A_VCTRL)
        vctrl <= i_wdata[13:0];
      if (i_addr == `VPSP_A_SCTRL)
        sctrl <= i_wdata[13:0];
      if (i_addr == `VPSP_A_SDIV)
        sdiv <= i_wdata[7:0];
    end
  end

  drive_load_a: assert property (
    gwr |=> o_drive_strength == $past(i_wdata[1:0])) else $error("drive strength not loaded");
  drive_hold_a: assert property (
    !gwr |=> $stable(o_drive_strength)) else $error("drive strength changed without write");
  v_mode_oe_a: assert property (
    $stable(vmode) |-> o_v_bclk_oe == vmode) else $error("voice clock enable wrong");
  s_mode_oe_a: assert property (
    $stable(smode) |-> o_s_bclk_oe == smode && o_s_fs_oe == smode) else $error("stereo clock enable wrong");
  v_off_quiet_a: assert property (
    !vctrl[0] && $stable(vctrl[0]) |-> !o_v_txd_oe && !o_v_txd) else $error("disabled voice port drives");
  s_bclk_half_a: assert property (
    disable iff (i_srst || !sclk4)
    $changed(o_s_bclk) |=> $stable(o_s_bclk) [*4] ##1 $changed(o_s_bclk)) else $error("bit clock half period");
  s_sync_width_a: assert property (
    disable iff (i_srst || !sshort)
    $rose(o_s_fs) |=> o_s_fs [*8] ##1 o_s_fs ##1 !o_s_fs) else $error("short sync width");
  s_txd_hold_a: assert property (
    disable iff (i_srst || !sclk4)
    $changed(o_s_txd) |=> $stable(o_s_txd) [*8] ##1 $stable(o_s_txd)) else $error("transmit bit period");

  fs_seen_c: cover property (smode && $rose(o_s_fs));
  drive_set_c: cover property (gwr);
  voice_on_c: cover property (vctrl[0] && o_v_txd_oe);
  v_master_c: cover property (vmode && o_v_bclk_oe);
endmodule

bind vpsp_top vpsp_top_props vpsp_top_props_inst (
  .i_ref_clk        (i_ref_clk),
  .i_srst           (i_srst),
  .i_addr           (i_addr),
  .i_wdata          (i_wdata),
  .i_wr             (i_wr),
  .o_drive_strength (o_drive_strength),
  .o_v_bclk_oe      (o_v_bclk_oe),
  .o_v_txd          (o_v_txd),
  .o_v_txd_oe       (o_v_txd_oe),
  .o_s_bclk         (o_s_bclk),
  .o_s_bclk_oe      (o_s_bclk_oe),
  .o_s_fs           (o_s_fs),
  .o_s_fs_oe        (o_s_fs_oe),
  .o_s_txd          (o_s_txd)
);

// file: vpsp_host_model.sv
// Host audio controller model on one serial bus
module vpsp_host_model (
  // Mode and word sent
  input  wire logic        i_gen,
  input  wire logic [15:0] i_word,
  // Resolved bus lines
  input  wire logic        i_bclk,
  input  wire logic        i_fs,
  input  wire logic        i_txd,
  // Host drivers
  output logic             o_bclk,
  output logic             o_fs,
  output logic             o_rxd
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] sh;
  logic [15:0] cap [0:3];
  int          ncap = 0;
  int          tcnt = 0;
  int          rcnt = 0;

  initial
  begin
    o_bclk = 1'b0;
    o_fs   = 1'b0;
    o_rxd  = 1'b0;
  end

  // Sync bit then 16 data bits, 400 ns bit clock, idle low after
  task automatic frame(input logic [15:0] w, output logic [15:0] got);
    o_fs   = 1'b1;
    o_bclk = 1'b1;
    o_rxd  = ~o_rxd;
    #200 o_bclk = 1'b0;
    #200;
    for (int i = 15; i >= 0; i--)
    begin
      o_bclk = 1'b1;
      o_fs   = 1'b0;
      o_rxd  = w[i];
      #200 o_bclk = 1'b0;
      #200 got[i] = i_txd;
    end
  endtask

  task automatic idle_bit();
    o_bclk = 1'b1;
    o_rxd  = ~o_rxd;
    #200 o_bclk = 1'b0;
    #200;
  endtask

  // Listener when the device makes clock and sync
  always @(negedge i_bclk)
  begin
    if (!i_gen)
    begin
      if (tcnt > 0)
      begin
        sh = {sh[14:0], i_txd};
        tcnt--;
        if (tcnt == 0 && ncap < 4)
        begin
          cap[ncap] = sh;
          ncap++;
        end
      end
      if (i_fs)
      begin
        tcnt = 16;
        rcnt = 16;
      end
    end
  end

  always @(posedge i_bclk)
  begin
    if (!i_gen && rcnt > 0)
    begin
      rcnt--;
      o_rxd = i_word[rcnt];
    end
    else if (!i_gen)
      o_rxd = ~o_rxd;
  end
endmodule

// file: tb.sv
// Self-checking bench of the serial audio ports
`include "vpsp_consts.vh"
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {logic [3:0] a; logic w; logic [31:0] d; logic [31:0] e;} vpsp_row_t;
  localparam vpsp_row_t ROWS [0:12] = '{
    '{`VPSP_A_VCTRL, 1'b0, 32'h0, 32'h00002000}, '{`VPSP_A_SCTRL, 1'b0, 32'h0, 32'h00002000},
    '{`VPSP_A_VDIV, 1'b0, 32'h0, 32'h00000004}, '{`VPSP_A_SDIV, 1'b0, 32'h0, 32'h00000004},
    '{`VPSP_A_GCTRL, 1'b0, 32'h0, 32'h0}, '{`VPSP_A_GCTRL, 1'b1, 32'hffffffff, 32'h00000003},
    '{`VPSP_A_GCTRL, 1'b1, 32'h2, 32'h00000002}, '{`VPSP_A_SDIV, 1'b1, 32'h1ff, 32'h000000ff},
    '{`VPSP_A_SDIV, 1'b1, 32'h4, 32'h00000004}, '{4'hc, 1'b0, 32'h0, 32'h0},
    '{4'hf, 1'b1, 32'h55, 32'h0}, '{`VPSP_A_STAT, 1'b0, 32'h0, 32'h0}, '{`VPSP_A_VRX, 1'b0, 32'h0, 32'h0}};
  logic        i_ref_clk, i_srst, i_wr, i_rd;
  logic [3:0]  i_addr;
  logic [31:0] i_wdata, v;
  logic [15:0] got;
  logic        v_gen = 1'b1;
  wire  [31:0] o_rdata;
  wire  [1:0]  o_drive_strength;
  wire         o_v_bclk, o_v_bclk_oe, o_v_fs, o_v_fs_oe, o_v_txd, o_v_txd_oe, hv_bclk, hv_fs, hv_rxd;
  wire         o_s_bclk, o_s_bclk_oe, o_s_fs, o_s_fs_oe, o_s_txd, o_s_txd_oe, hs_bclk, hs_fs, hs_rxd;
  wire         v_bclk = o_v_bclk_oe ? o_v_bclk : hv_bclk;
  wire         v_fs   = o_v_fs_oe ? o_v_fs : hv_fs;
  wire         v_txd  = o_v_txd_oe ? o_v_txd : 1'bz;
  wire         s_bclk = o_s_bclk_oe ? o_s_bclk : hs_bclk;
  wire         s_fs   = o_s_fs_oe ? o_s_fs : hs_fs;
  wire         s_txd  = o_s_txd_oe ? o_s_txd : 1'bz;
  int          failures = 0;
  int          samples_checked = 0;

  vpsp_top vpsp_top_inst (.i_ref_clk(i_ref_clk), .i_srst(i_srst), .i_ce(1'b1), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_drive_strength(o_drive_strength),
    .i_v_bclk(v_bclk), .i_v_fs(v_fs), .i_v_rxd(hv_rxd), .o_v_bclk(o_v_bclk), .o_v_bclk_oe(o_v_bclk_oe),
    .o_v_fs(o_v_fs), .o_v_fs_oe(o_v_fs_oe), .o_v_txd(o_v_txd), .o_v_txd_oe(o_v_txd_oe),
    .i_s_bclk(s_bclk), .i_s_fs(s_fs), .i_s_rxd(hs_rxd), .o_s_bclk(o_s_bclk), .o_s_bclk_oe(o_s_bclk_oe),
    .o_s_fs(o_s_fs), .o_s_fs_oe(o_s_fs_oe), .o_s_txd(o_s_txd), .o_s_txd_oe(o_s_txd_oe));
  vpsp_host_model vpsp_host_model_inst (.i_gen(v_gen), .i_word(16'h0), .i_bclk(v_bclk), .i_fs(v_fs),
    .i_txd(v_txd), .o_bclk(hv_bclk), .o_fs(hv_fs), .o_rxd(hv_rxd));
  vpsp_host_model vpsp_host_model_inst_s (.i_gen(1'b0), .i_word(16'h7e81), .i_bclk(s_bclk), .i_fs(s_fs),
    .i_txd(s_txd), .o_bclk(hs_bclk), .o_fs(hs_fs), .o_rxd(hs_rxd));

  function automatic logic [15:0] tx_of(int n);
    return {n[3:0], 4'h5, ~n[3:0], 4'ha};
  endfunction
  function automatic logic [31:0] rx_of(int n);
    return {{17{~n[3]}}, ~n[2:0], 4'hc, n[3:0], 4'h3};
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      failures++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge i_ref_clk);
    i_wr    <= 1'b1;
    i_addr  <= a;
    i_wdata <= d;
    @(posedge i_ref_clk);
    i_wr    <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge i_ref_clk);
    i_rd   <= 1'b1;
    i_addr <= a;
    @(posedge i_ref_clk);
    i_rd   <= 1'b0;
    @(negedge i_ref_clk);
    d = o_rdata;
  endtask
  task automatic give_verdict();
    if (failures == 0 && samples_checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  initial
  begin
    i_ref_clk = 1'b0;
    forever #25 i_ref_clk = ~i_ref_clk;
  end
  initial
  begin
    #1000000;
    failures++;
    give_verdict();
  end

  initial
  begin
    {i_srst, i_wr, i_rd, i_addr, i_wdata} = {1'b1, 38'h0};
    repeat (16) @(posedge i_ref_clk);
    i_srst <= 1'b0;
    for (int k = 0; k < 13; k++)
    begin
      if (ROWS[k].w)
        wr(ROWS[k].a, ROWS[k].d);
      rd(ROWS[k].a, v);
      check(v, ROWS[k].e);
    end
    // Stereo master runs beside the voice slave
    wr(`VPSP_A_STX, 32'h3c96);
    wr(`VPSP_A_STX, 32'hc35a);
    wr(`VPSP_A_SCTRL, 32'h2007);
    for (int i = 0; i < 16; i++)
      wr(`VPSP_A_VTX, {16'h0, tx_of(i)});
    rd(`VPSP_A_STAT, v);
    check(v & 32'h5, 32'h1);
    wr(`VPSP_A_VTX, 32'hdead);
    wr(`VPSP_A_VCTRL, 32'h2001);
    repeat (4) @(negedge i_ref_clk);
    check({31'h0, o_v_txd_oe}, 32'h0);
    #17;
    for (int i = 0; i < 17; i++)
    begin
      vpsp_host_model_inst.frame(16'(rx_of(i)), got);
      check({16'h0, got}, {16'h0, (i < 16) ? tx_of(i) : 16'h0});
    end
    vpsp_host_model_inst.idle_bit();
    rd(`VPSP_A_VRATE, v);
    check({31'h0, v >= 32'd135 && v <= 32'd137}, 32'h1);
    rd(`VPSP_A_STAT, v);
    check(v & 32'hffffffdf, 32'h000000da);
    check({16'h0, vpsp_host_model_inst_s.cap[0]}, 32'hc35a);
    check({16'h0, vpsp_host_model_inst_s.cap[1]}, 32'h0);
    check({31'h0, o_s_txd_oe}, 32'h1);
    for (int i = 0; i < 16; i++)
    begin
      rd(`VPSP_A_VRX, v);
      check(v, rx_of(i));
    end
    rd(`VPSP_A_SRX, v);
    rd(`VPSP_A_SRX, v);
    check(v, 32'h00007e81);
    wr(`VPSP_A_SCTRL, 32'h2003);
    repeat (4) @(negedge i_ref_clk);
    check({31'h0, o_s_bclk_oe}, 32'h0);
    wr(`VPSP_A_STAT, 32'hf0);
    rd(`VPSP_A_STAT, v);
    check(v & 32'hf3, 32'h0);
    wr(`VPSP_A_VCTRL, 32'h0001);
    repeat (4) @(negedge i_ref_clk);
    check({30'h0, o_v_txd_oe, o_v_txd}, 32'h2);
    // Voice master feeds the host listener
    v_gen <= 1'b0;
    wr(`VPSP_A_VTX, 32'h9a5c);
    wr(`VPSP_A_VTX, 32'h63b1);
    wr(`VPSP_A_VCTRL, 32'h2007);
    repeat (520) @(negedge i_ref_clk);
    check({30'h0, o_v_bclk_oe, o_v_fs_oe}, 32'h3);
    check({16'h0, vpsp_host_model_inst.cap[0]}, 32'h63b1);
    check({16'h0, vpsp_host_model_inst.cap[1]}, 32'h0);
    give_verdict();
  end
endmodule
